// File: hw/asfs_sequencer.sv
`timescale 1ns/1ps
// Function
// RQ1 - Start conversion, raise busy after sixteenth fall
// RQ2 - Busy high during conversion, at most 365ns
// RQ3 - Frame sync during conversion aborts it
// RQ4 - Chip-select fall during conversion aborts it
// RQ5 - Frame sync after ninth rise aborts frame
// RQ6 - Chip-select rise after ninth rise aborts frame
// RQ7 - Host holds chip-select past sixteenth fall
// RQ8 - Data output released when chip-select high
// RQ9 - Later bits driven on rising serial clock
// RQ10 - MSB presented when frame sync rises
// RQ11 - MSB presented when chip-select falls
// RQ12 - Host sets chip-select before frame sync
// RQ13 - Short low pulse resets without power-down
// RQ14 - Long low pulse enters power-down
// RQ15 - Power-up takes up to 25ms
// RQ16 - Data output released on power-down fall
// RQ17 - Sixteen clocks: wake eighth, track ninth
// RQ18 - Result shifted out MSB first
// RQ19 - Frame start outputs previous MSB
// RQ20 - Frame style chosen by starting edge
module asfs_sequencer
   import asfs_pkg::*;
#(
   parameter int POWERUP_COUNT = POWERUP_CYCLES,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic chipSelect_n,
   input wire logic frameSync,
   input wire logic powerdownReset_n,
   input wire logic [RESULT_BITS-1:0] sampleIn,
   output logic sdoOut,
   output logic sdoOe,
   output logic busy,
   output logic dspMode,
   output logic napWake,
   output logic tracking,
   output logic powerDown,
   output logic [RESULT_BITS-1:0] resultData,
   output logic resultValid,
   input wire logic resultReady
);
   initial begin
      if (POWERUP_COUNT < 1) $error("POWERUP_COUNT must be positive");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic [3:0] prev_q;

   // Two flip-flops per pin, then a history stage for edge detection.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         // Idle levels: serial clock low, select high, sync low, power pin high.
         meta_q <= 4'h5;
         sync_q <= 4'h5;
         prev_q <= 4'h5;
      end else begin
         meta_q <= {sclk, chipSelect_n, frameSync, powerdownReset_n};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   wire sclkS = sync_q[3];
   wire csS = sync_q[2];
   wire fsS = sync_q[1];
   wire pwdS = sync_q[0];
   wire sclkRise = sclkS && !prev_q[3];
   wire sclkFall = !sclkS && prev_q[3];
   wire csFall = !csS && prev_q[2];
   wire csRise = csS && !prev_q[2];
   wire fsRise = fsS && !prev_q[1];
   wire pwdFall = !pwdS && prev_q[0];
   wire pwdRise = pwdS && !prev_q[0];

   ////////////////////////////////////////////////////////////////////////////////
   // State and counters.

   asfs_state_e state_q;
   asfs_state_e state_d;
   logic [4:0] riseCnt_q;
   logic [4:0] fallCnt_q;
   logic [8:0] timer_q;
   logic [12:0] pwdLowCnt_q;
   logic [22:0] upCnt_q;
   logic [RESULT_BITS-1:0] result_q;
   logic [RESULT_BITS-1:0] shift_q;
   logic dsp_q;
   logic abortSeen_q;

   // Frame start: frame sync with chip-select low, or chip-select falling.
   wire startDsp = fsRise && !csS; // [RQ20]
   wire startSpi = csFall; // [RQ20]
   wire frameStart = startDsp || startSpi; // [RQ19]
   wire active = (state_q != ST_POWERDOWN) && (state_q != ST_POWERUP);
   // Abort during sampling: only after the ninth rising edge.
   wire pastTrack = (riseCnt_q >= 5'(TRACK_EDGE));
   wire frameAbort = (state_q == ST_FRAME) && pastTrack && (dsp_q ? fsRise : csRise); // [RQ5] [RQ6]
   wire sixteenth = (state_q == ST_FRAME) && sclkFall
      && (fallCnt_q == 5'(FRAME_CLOCKS - 1)); // [RQ1] [RQ17]
   wire convDone = (state_q == ST_CONVERT) && (timer_q == 9'(CONV_CYCLES - 1));
   // Long low pulse on the power-down pin.
   wire pwdLong = !pwdS && (pwdLowCnt_q >= 13'(POWERDOWN_CYCLES)); // [RQ14]
   // Short pulse within the reset window on release.
   wire pwdShort = pwdRise && (pwdLowCnt_q >= 13'(RESET_MIN_CYCLES))
      && (pwdLowCnt_q <= 13'(RESET_MAX_CYCLES)); // [RQ13]

   // Next state selection.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (frameStart) state_d = ST_FRAME;
         end
         ST_FRAME: begin
            if (sixteenth) state_d = ST_CONVERT;
            else if (frameAbort) state_d = dsp_q ? ST_FRAME : ST_IDLE; // [RQ5] [RQ6]
            else if (frameStart) state_d = ST_FRAME;
         end
         ST_CONVERT: begin
            if (frameStart) state_d = ST_FRAME; // [RQ3] [RQ4]
            else if (convDone) state_d = ST_GUARD;
         end
         ST_GUARD: begin
            if (frameStart) state_d = ST_FRAME; // [RQ3] [RQ4]
            else if (timer_q == 9'(GUARD_CYCLES - 1)) state_d = ST_IDLE;
         end
         ST_POWERDOWN: begin
            if (pwdRise) state_d = ST_POWERUP;
         end
         ST_POWERUP: begin
            if (upCnt_q == 23'(POWERUP_COUNT - 1)) state_d = ST_IDLE; // [RQ15]
         end
         default: state_d = ST_IDLE;
      endcase
      if (pwdLong) state_d = ST_POWERDOWN;
      else if (pwdShort || (!pwdS && active)) state_d = ST_IDLE; // [RQ13]
   end

   // State register.
   always_ff @(posedge clk) begin
      if (!reset_n) state_q <= ST_IDLE;
      else state_q <= state_d;
   end

   // Conversion and guard timer restarts at each state change.
   always_ff @(posedge clk) begin
      if (!reset_n || state_d != state_q) timer_q <= '0;
      else timer_q <= timer_q + 1'b1;
   end

   // Power-down pin low-time and power-up counters.
   always_ff @(posedge clk) begin
      if (!reset_n || pwdS) pwdLowCnt_q <= '0;
      else if (!pwdLong) pwdLowCnt_q <= pwdLowCnt_q + 1'b1;
      if (!reset_n || state_q != ST_POWERUP) upCnt_q <= '0;
      else upCnt_q <= upCnt_q + 1'b1;
   end

   // Serial clock edge counters within the frame.
   always_ff @(posedge clk) begin
      if (!reset_n || frameStart || state_q != ST_FRAME) begin
         riseCnt_q <= '0;
         fallCnt_q <= '0;
      end else begin
         if (sclkRise && riseCnt_q != 5'h1f) riseCnt_q <= riseCnt_q + 1'b1;
         if (sclkFall && fallCnt_q != 5'h1f) fallCnt_q <= fallCnt_q + 1'b1;
      end
   end

   // Result capture at conversion end and shift register for output.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         result_q <= RESULT_RESET;
         shift_q <= RESULT_RESET;
         dsp_q <= 1'b0;
      end else begin
         if (convDone) result_q <= sampleIn;
         if (frameStart) begin
            shift_q <= result_q; // [RQ18] [RQ19]
            dsp_q <= startDsp;
         end else if (state_q == ST_FRAME && sclkRise && riseCnt_q < 5'(RESULT_BITS - 1)) begin
            shift_q <= {shift_q[RESULT_BITS-2:0], 1'b0}; // [RQ9] [RQ18]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result stream buffering.

   logic fifoInReady;

   // Abandoned results are not pushed; a full FIFO drops the newest result.
   always_ff @(posedge clk) begin
      if (!reset_n) abortSeen_q <= 1'b0;
      else abortSeen_q <= convDone && !fifoInReady;
   end

   asfs_fifo #(
      .WIDTH(RESULT_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .inData(sampleIn),
      .inValid(convDone),
      .inReady(fifoInReady),
      .outData(resultData),
      .outValid(resultValid),
      .outReady(resultReady)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Output registers.

   // Pin outputs come straight from flip-flops.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sdoOut <= 1'b0;
         sdoOe <= 1'b0;
         busy <= 1'b0;
         dspMode <= 1'b0;
         napWake <= 1'b0;
         tracking <= 1'b0;
         powerDown <= 1'b0;
      end else begin
         sdoOut <= frameStart ? result_q[RESULT_BITS-1] : shift_q[RESULT_BITS-1]; // [RQ10] [RQ11]
         sdoOe <= !csS && pwdS && !pwdFall && active; // [RQ8] [RQ16]
         busy <= (state_d == ST_CONVERT); // [RQ1] [RQ2]
         dspMode <= frameStart ? startDsp : dsp_q;
         napWake <= (state_d == ST_FRAME) && (riseCnt_q >= 5'(NAP_WAKE_EDGE)); // [RQ17]
         tracking <= (state_d == ST_FRAME) && pastTrack; // [RQ17]
         powerDown <= (state_d == ST_POWERDOWN) || (state_d == ST_POWERUP);
      end
   end
endmodule : asfs_sequencer

// File: hw/asfs_pkg.sv
package asfs_pkg;
   // Frame geometry in serial clocks.
   localparam int FRAME_CLOCKS = 16;
   localparam int RESULT_BITS = 14;
   localparam int NAP_WAKE_EDGE = 8;
   localparam int TRACK_EDGE = 9;
   // Timing figures in their own units.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int BUSY_DELAY_NS = 40;
   localparam int CONV_TIME_NS = 365;
   localparam int ABORT_GUARD_NS = 10;
   localparam int RESET_PULSE_MIN_NS = 45;
   localparam int RESET_PULSE_MAX_NS = 6140;
   localparam int POWERDOWN_PULSE_NS = 7200;
   localparam int POWERUP_MS = 25;
   // Derived cycle counts: least times round up, longest times round down.
   localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS - 4;
   localparam int GUARD_CYCLES = (ABORT_GUARD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESET_MIN_CYCLES = (RESET_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int RESET_MAX_CYCLES = (RESET_PULSE_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int POWERDOWN_CYCLES = (POWERDOWN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int POWERUP_CYCLES = (POWERUP_MS * 1000000) / (CLK_PERIOD_PS / 1000);
   // Reset values.
   localparam logic [13:0] RESULT_RESET = 14'h0000;

   // Frame sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FRAME,
      ST_CONVERT,
      ST_GUARD,
      ST_POWERDOWN,
      ST_POWERUP
   } asfs_state_e;

   // Serial data pin as value and enable.
   typedef struct packed {
      logic data;
      logic oe;
   } asfs_sdo_s;
endpackage : asfs_pkg

// File: hw/asfs_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO with valid/ready on both sides.
module asfs_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   wire isEmpty = (wrPtr_q == rdPtr_q);
   wire isFull = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
   wire doWrite = inValid && !isFull;
   wire doRead = outReady && !isEmpty;

   assign inReady = !isFull;
   assign outValid = !isEmpty;
   assign outData = mem[rdPtr_q[AW-1:0]];

   // Storage write.
   always_ff @(posedge clk) begin
      if (doWrite) mem[wrPtr_q[AW-1:0]] <= inData;
   end

   // Pointer update.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (doWrite) wrPtr_q <= wrPtr_q + 1'b1;
         if (doRead) rdPtr_q <= rdPtr_q + 1'b1;
      end
   end
endmodule : asfs_fifo

// File: tb/asfs_sequencer_asserts.sv
`timescale 1ns/1ps
// Watches the sequencer pins for timing and ordering slips.
module asfs_sequencer_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic frameSync,
   input wire logic powerdownReset_n,
   input wire logic sdoOe,
   input wire logic busy,
   input wire logic dspMode,
   input wire logic napWake,
   input wire logic tracking,
   input wire logic powerDown
);
   logic [6:0] busyCnt_q;
   logic [11:0] lowCnt_q;
   // Counts the busy width and how long the power pin has been low.
   always_ff @(posedge clk) begin
      busyCnt_q <= busy ? busyCnt_q + 7'h01 : 7'h00;
      lowCnt_q <= powerdownReset_n ? 12'h000 : lowCnt_q + 12'(lowCnt_q != 12'hfff);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_start(logic m);
      ##[1:6] (sdoOe && dspMode == m);
   endsequence
   // Each property ties an output to the pin activity that causes it, except the busy width and wake order checks.
   property p_busyMax; busy |-> busyCnt_q < 7'h5b; endproperty
   a_busyMax: assert property (p_busyMax) else $error("busy too long");
   property p_csOff; $rose(chipSelect_n) |-> ##[1:5] (!sdoOe [*3]); endproperty
   a_csOff: assert property (p_csOff) else $error("data not released");
   property p_pwdOff; $fell(powerdownReset_n) |-> ##[1:4] (!sdoOe && !busy); endproperty
   a_pwdOff: assert property (p_pwdOff) else $error("no release on reset");
   property p_spiGo;
      $fell(chipSelect_n) && !frameSync && powerdownReset_n && !powerDown |-> s_start(1'b0);
   endproperty
   a_spiGo: assert property (p_spiGo) else $error("select start");
   property p_dspGo;
      $rose(frameSync) && !chipSelect_n && powerdownReset_n && !powerDown |-> s_start(1'b1);
   endproperty
   a_dspGo: assert property (p_dspGo) else $error("sync start");
   property p_napOrder; $rose(tracking) |-> $past(napWake, 4); endproperty
   a_napOrder: assert property (p_napOrder) else $error("wake order");
   property p_pdMin; $rose(powerDown) |-> lowCnt_q >= 12'h708; endproperty
   a_pdMin: assert property (p_pdMin) else $error("early power-down");
   property p_shortRst;
      $rose(powerdownReset_n) && lowCnt_q < 12'h600 && !powerDown |-> (!powerDown && !busy) [*8];
   endproperty
   a_shortRst: assert property (p_shortRst) else $error("short pulse");
endmodule : asfs_sequencer_asserts
bind asfs_sequencer asfs_sequencer_asserts chk (.clk(clk), .reset_n(reset_n),
   .chipSelect_n(chipSelect_n), .frameSync(frameSync), .powerdownReset_n(powerdownReset_n),
   .sdoOe(sdoOe), .busy(busy), .dspMode(dspMode), .napWake(napWake), .tracking(tracking),
   .powerDown(powerDown));

// File: tb/asfs_host_model.sv
`timescale 1ns/1ps
// Host serial port: an SPI master or a DSP port with frame sync.
module asfs_host_model (
   output logic sclk,
   output logic chipSelect_n,
   output logic frameSync,
   output logic powerdownReset_n,
   input wire logic sdoOut,
   input wire logic sdoOe
);
   logic [13:0] word;
   realtime lastFall;
   // A released data line reads as its pull-up level.
   wire logic sdoLine = sdoOe ? sdoOut : 1'b1;
   // Pins start idle with the serial clock parked low.
   initial begin
      sclk = 1'b0;
      chipSelect_n = 1'b1;
      frameSync = 1'b0;
      powerdownReset_n = 1'b1;
   end
   // Runs a frame of 16 clocks, or cuts it after the ninth rising edge.
   task automatic frame(input bit dsp, input bit cut);
      if (dsp) begin
         frameSync = 1'b1;
         #20 frameSync = 1'b0;
      end else begin
         chipSelect_n = 1'b0;
      end
      #40;
      for (int i = 1; i <= 16; i++) begin
         if (i <= 14) word[14-i] = sdoLine;
         sclk = 1'b1;
         #62.5;
         if (cut && i == 9) begin
            frameSync = dsp;
            chipSelect_n = !dsp;
            #20 frameSync = 1'b0;
            sclk = 1'b0;
            return;
         end
         sclk = 1'b0;
         lastFall = $realtime;
         #62.5 chipSelect_n = (i == 16) ? !dsp : chipSelect_n;
      end
      #20;
   endtask : frame
endmodule : asfs_host_model

// File: tb/test_adc_serial_frame_sequencer.sv
`timescale 1ns/1ps
// Self-checking bench for the serial frame sequencer.
module test_adc_serial_frame_sequencer;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic resultReady = 1'b0;
   logic [13:0] sampleIn = 14'h0000;
   logic [13:0] resultData;
   logic sclk, chipSelect_n, frameSync, powerdownReset_n, sdoOut, sdoOe, busy, dspMode;
   logic napWake, tracking, powerDown, resultValid;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   realtime busyRise;
   asfs_sequencer #(.POWERUP_COUNT(50)) dut (.clk(clk), .reset_n(reset_n), .sclk(sclk),
      .chipSelect_n(chipSelect_n), .frameSync(frameSync), .powerdownReset_n(powerdownReset_n),
      .sampleIn(sampleIn), .sdoOut(sdoOut), .sdoOe(sdoOe), .busy(busy), .dspMode(dspMode),
      .napWake(napWake), .tracking(tracking), .powerDown(powerDown), .resultData(resultData),
      .resultValid(resultValid), .resultReady(resultReady));
   asfs_host_model host (.sclk(sclk), .chipSelect_n(chipSelect_n), .frameSync(frameSync),
      .powerdownReset_n(powerdownReset_n), .sdoOut(sdoOut), .sdoOe(sdoOe));
   // Clock, busy edge stamp and the hang limit.
   always #2 clk = ~clk;
   always @(posedge busy) busyRise = $realtime;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic flag(input logic seen, input logic want);
      check({15'h0000, seen}, {15'h0000, want});
   endtask : flag
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic setSample(input logic [13:0] v);
      @(posedge clk);
      #1 sampleIn = v;
   endtask : setSample
   // Checks the head of the result buffer, then pops it.
   task automatic pop(input logic [13:0] want);
      flag(resultValid, 1'b1);
      check({2'h0, resultData}, {2'h0, want});
      @(posedge clk);
      #1 resultReady = 1'b1;
      @(posedge clk);
      #1 resultReady = 1'b0;
   endtask : pop
   task automatic test_spi();
      setSample(14'h2a5c);
      host.frame(1'b0, 1'b0);
      check(16'(busyRise > host.lastFall && busyRise - host.lastFall <= 40.0), 16'h0001);
      flag(busy, 1'b1);
      flag(dspMode, 1'b0);
      #500 pop(14'h2a5c);
      flag(busy, 1'b0);
      setSample(14'h1333);
      host.frame(1'b0, 1'b0);
      check({2'h0, host.word}, 16'h2a5c);
      #500 pop(14'h1333);
      $display("spi test done");
   endtask : test_spi
   task automatic test_dsp();
      host.chipSelect_n = 1'b0;
      #40;
      setSample(14'h0f0f);
      host.frame(1'b1, 1'b0);
      flag(dspMode, 1'b1);
      check({2'h0, host.word}, 16'h1333);
      #500 pop(14'h0f0f);
      host.chipSelect_n = 1'b1;
      #40 $display("dsp test done");
   endtask : test_dsp
   // Cuts a frame while sampling, then restarts one during conversion.
   task automatic test_abort();
      for (int d = 0; d < 2; d++) begin
         host.chipSelect_n = !d[0];
         #40;
         setSample(14'h3c01);
         host.frame(d[0], 1'b1);
         #600 flag(resultValid, 1'b0);
         flag(tracking, 1'b0);
         flag(napWake, 1'b0);
         host.frame(d[0], 1'b0);
         host.frame(d[0], 1'b0);
         #600 pop(14'h3c01);
         flag(resultValid, 1'b0);
      end
      host.chipSelect_n = 1'b1;
      #40 $display("abort test done");
   endtask : test_abort
   // Fills the buffer past full with the reader stalled, then drains it.
   task automatic test_fifo();
      for (int i = 0; i < 17; i++) begin
         setSample(14'(i) + 14'h0100);
         host.frame(1'b0, 1'b0);
         #600;
      end
      for (int i = 0; i < 16; i++) pop(14'(i) + 14'h0100);
      flag(resultValid, 1'b0);
      $display("fifo test done");
   endtask : test_fifo
   task automatic test_pwd();
      host.chipSelect_n = 1'b0;
      #40 flag(sdoOe, 1'b1);
      host.powerdownReset_n = 1'b0;
      #24 flag(sdoOe, 1'b0);
      #376 host.powerdownReset_n = 1'b1;
      host.chipSelect_n = 1'b1;
      #100 flag(powerDown, 1'b0);
      host.powerdownReset_n = 1'b0;
      #8000 flag(powerDown, 1'b1);
      host.powerdownReset_n = 1'b1;
      #100 flag(powerDown, 1'b1);
      #400 flag(powerDown, 1'b0);
      $display("power test done");
   endtask : test_pwd
   // Reset, then every scenario in turn.
   initial begin
      repeat (4) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk);
      test_spi();
      test_dsp();
      test_abort();
      test_fifo();
      test_pwd();
      tally_and_finish();
   end
endmodule : test_adc_serial_frame_sequencer
